// ---- include/tpm_pkg.sv ----
// Constants, register map and state types of the measurement timer block.
// Assumes a plain register port with byte addresses and 32-bit data.
package tpm_pkg;
  // Instance placement on the controller bus
  localparam int          TPM_NUM_INST    = 4;
  localparam logic [31:0] TPM_BUS_BASE    = 32'h4002_0000;
  localparam logic [31:0] TPM_FIRST_OFS   = 32'h0000_0c00;
  localparam logic [31:0] TPM_INST_STRIDE = 32'h0000_0080;
  localparam int          TPM_STRIDE_SH   = 7;
  // Register offsets inside one instance
  localparam logic [6:0]  TPM_OFS_CTL     = 7'h00;
  localparam logic [6:0]  TPM_OFS_CLK     = 7'h04;
  localparam logic [6:0]  TPM_OFS_RELOAD  = 7'h08;
  localparam logic [6:0]  TPM_OFS_COUNT   = 7'h0c;
  localparam logic [6:0]  TPM_OFS_STAT    = 7'h10;
  localparam logic [6:0]  TPM_OFS_MASK    = 7'h14;
  // Control register fields
  localparam int          TPM_CTL_EN      = 0;
  localparam int          TPM_CTL_RST     = 1;
  localparam int          TPM_CTL_MEAS    = 2;
  localparam int          TPM_CTL_BYP     = 8;
  localparam int          TPM_CTL_SLEEP   = 11;
  // Clock and edge register fields
  localparam int          TPM_CLK_TPS     = 0;
  localparam int          TPM_CLK_FPS     = 4;
  localparam int          TPM_CLK_RISE    = 8;
  localparam int          TPM_CLK_FALL    = 9;
  // Status and mask fields
  localparam int          TPM_ST_MEAS     = 0;
  localparam int          TPM_ST_OVF      = 1;
  localparam int          TPM_ST_PIN      = 4;
  // Counter values and reset values
  localparam logic [15:0] TPM_CNT_MAX     = 16'hffff;
  localparam logic [15:0] TPM_CNT_ZERO    = 16'h0000;
  localparam logic [15:0] TPM_RELOAD_RST  = 16'h0000;
  localparam logic [1:0]  TPM_MASK_RST    = 2'h0;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_WAIT,
    PH_RUN,
    PH_HALT
  } tpm_phase_e;

  typedef struct packed {
    logic        enable;
    logic        soft_rst;
    logic        meas_mode;
    logic        bypass;
    logic        rise_en;
    logic        fall_en;
    logic [2:0]  tps;
    logic [2:0]  fps;
    logic [7:0]  pcnt;
    logic [15:0] reload;
    logic [15:0] count;
    tpm_phase_e  phase;
    logic        seen_r;
    logic        seen_f;
    logic [1:0]  st;
    logic [1:0]  mask;
  } tpm_tmr_s;

  typedef struct packed {
    logic [1:0] sync;
    logic [2:0] hist;
    logic       filt;
    logic       prev;
  } tpm_det_s;
endpackage : tpm_pkg

// ---- include/tpm_edge_if.sv ----
// Carries the input pin, filter controls and detected edges between the
// timer core and its edge detector.
`timescale 1ns/10ps
interface tpm_edge_if;
  logic pin;
  logic bypass;
  logic ftick;
  logic rise;
  logic fall;
  logic level;
  modport det (input pin, bypass, ftick, output rise, fall, level);
  modport tmr (output pin, bypass, ftick, input rise, fall, level);
endinterface : tpm_edge_if

// ---- logic/tpm_edge_det.sv ----
// Synchroniser, noise filter and edge detector for one measurement input.
// Assumes ftick is a one-cycle filter sampling strobe.
`timescale 1ns/10ps
module tpm_edge_det
  import tpm_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Pin and edges
  tpm_edge_if.det   eif
);
  tpm_det_s s_q;
  tpm_det_s s_d;
  logic     sel;

  // Filtered level changes only after three equal samples
  always_comb begin
    s_d      = s_q;
    s_d.sync = {s_q.sync[0], eif.pin};
    if (eif.ftick) begin
      s_d.hist = {s_q.hist[1:0], s_q.sync[1]};
      if (s_q.hist == 3'h7) begin
        s_d.filt = 1'b1;
      end else if (s_q.hist == 3'h0) begin
        s_d.filt = 1'b0;
      end
    end
    sel = eif.bypass ? s_q.sync[1] : s_q.filt; // R17
    s_d.prev = sel;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // One event per clock at most, from successive samples
  assign eif.rise  = sel & ~s_q.prev; // R19
  assign eif.fall  = ~sel & s_q.prev; // R19
  assign eif.level = s_q.sync[1];
endmodule : tpm_edge_det

// ---- logic/tpm_top.sv ----
// Four 16-bit timers in pulse width / period measurement mode.
// Assumes a single-cycle register port; pins are synchronous inputs.
//
// How it works
// (R1) Count up from zero, top 0xFFFF
// (R2) Edge copies count to reload, restart
// (R3) Counting starts only with enable set
// (R4) Reset control, overflow or disable stop
// (R5) Interrupt on overflow and edges, not first
// (R6) Reload reads last result, zero on overflow
// (R7) Reload read-only in measurement mode
// (R8) Pin is general input or measure input
// (R9) Both edges selected gives pulse width
// (R10) Measurement begins at next qualifying edge
// (R11) Pulse overflow zeroes reload, clears enable
// (R12) Pulse interrupt needs rising and falling seen
// (R13) Period counts between same-polarity edges
// (R14) Period overflow zeroes reload
// (R15) Period interrupt needs two selected edges
// (R16) Four instances at 0x0C00 plus 0x80 steps
// (R17) Bit 8 bypasses the input noise filter
// (R18) Sleep holds timer reset, keeps enable
// (R19) Synchronised input, edges from successive samples
`timescale 1ns/10ps
module tpm_top
  import tpm_pkg::*;
#(
  parameter int NUM_INST = TPM_NUM_INST
)(
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Register port
  input  wire logic [31:0]         addr_i,
  input  wire logic [31:0]         wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic      [31:0]         rdata_o,
  // Measurement pins and sleep requests
  input  wire logic [NUM_INST-1:0] measure_input_pin_i,
  input  wire logic [NUM_INST-1:0] sleep_req_i,
  // Interrupt to the embedded controller
  output logic                     irq_o
);

  // Bus decode shared by all instances
  logic [31:0]         ofs;
  logic                hit;
  logic [1:0]          inst;
  logic [6:0]          roff;
  logic [31:0]         rd_vec [NUM_INST];
  logic [NUM_INST-1:0] irq_vec;
  logic [31:0]         rdata_q;
  logic [31:0]         rdata_d;

  assign ofs  = addr_i - (TPM_BUS_BASE + TPM_FIRST_OFS); // R16
  assign hit  = ofs < (TPM_INST_STRIDE * NUM_INST); // R16
  assign inst = ofs[TPM_STRIDE_SH+1:TPM_STRIDE_SH]; // R16
  assign roff = {ofs[6:2], 2'h0};

  for (genvar n = 0; n < NUM_INST; n++) begin : g_tmr
    tpm_edge_if eif ();
    tpm_tmr_s   t_q;
    tpm_tmr_s   t_d;
    logic       wsel;
    logic       sleep;
    logic       active;
    logic       pulse;
    logic       eff;
    logic       tick;
    logic [7:0] tmask;
    logic [7:0] fmask;
    logic       ev_meas;
    logic       ev_ovf;
    logic       nr;
    logic       nf;

    tpm_edge_det u_det (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .eif   (eif.det)
    );

    assign eif.pin    = measure_input_pin_i[n];
    assign eif.bypass = t_q.bypass;
    assign tmask = 8'((16'h1 << t_q.tps) - 16'h1);
    assign fmask = 8'((16'h1 << t_q.fps) - 16'h1);
    assign eif.ftick = (t_q.pcnt & fmask) == fmask;
    assign tick  = (t_q.pcnt & tmask) == tmask;
    assign wsel  = wr_i & hit & (inst == 2'(n));
    assign sleep = sleep_req_i[n];
    // Both polarities selected means pulse width, else period
    assign pulse = t_q.rise_en & t_q.fall_en; // R9
    assign eff = (eif.rise & t_q.rise_en) |
                 (eif.fall & t_q.fall_en); // R13
    assign active = t_q.enable & t_q.meas_mode &
                    ~t_q.soft_rst & ~sleep; // R4

    always_comb begin
      t_d     = t_q;
      ev_meas = 1'b0;
      ev_ovf  = 1'b0;
      nr      = t_q.seen_r | eif.rise;
      nf      = t_q.seen_f | eif.fall;
      t_d.pcnt = t_q.pcnt + 8'h1;

      // Register writes
      if (wsel) begin
        unique case (roff)
          TPM_OFS_CTL: begin
            t_d.enable    = wdata_i[TPM_CTL_EN];
            t_d.soft_rst  = wdata_i[TPM_CTL_RST];
            t_d.meas_mode = wdata_i[TPM_CTL_MEAS];
            t_d.bypass    = wdata_i[TPM_CTL_BYP]; // R17
          end
          TPM_OFS_CLK: begin
            t_d.tps     = wdata_i[TPM_CLK_TPS +: 3];
            t_d.fps     = wdata_i[TPM_CLK_FPS +: 3];
            t_d.rise_en = wdata_i[TPM_CLK_RISE];
            t_d.fall_en = wdata_i[TPM_CLK_FALL];
          end
          TPM_OFS_RELOAD: begin
            if (!t_q.meas_mode) begin // R7
              t_d.reload = wdata_i[15:0];
            end
          end
          TPM_OFS_STAT: begin
            t_d.st = t_q.st & ~wdata_i[1:0];
          end
          TPM_OFS_MASK: begin
            t_d.mask = wdata_i[1:0];
          end
          default: begin
          end
        endcase
      end

      // Measurement sequence
      if (!active) begin
        // Sleep and reset control hold the counter at zero
        t_d.count  = TPM_CNT_ZERO; // R18
        t_d.seen_r = 1'b0;
        t_d.seen_f = 1'b0;
        if (t_q.enable && t_q.meas_mode) begin
          t_d.phase = PH_WAIT; // R18
        end else begin
          t_d.phase = PH_IDLE; // R4
        end
      end else begin
        unique case (t_q.phase)
          PH_IDLE: begin
            t_d.phase = PH_WAIT; // R3
          end
          PH_WAIT: begin
            // First qualifying edge only arms, no interrupt
            if (eff) begin // R10
              t_d.phase  = PH_RUN;
              t_d.count  = TPM_CNT_ZERO; // R1
              t_d.seen_r = eif.rise;
              t_d.seen_f = eif.fall;
            end
          end
          PH_RUN: begin
            if (eff) begin
              t_d.reload = t_q.count; // R2
              t_d.count  = TPM_CNT_ZERO; // R2
              t_d.seen_r = nr;
              t_d.seen_f = nf;
              if (pulse) begin
                ev_meas = nr & nf; // R12
              end else begin
                ev_meas = 1'b1; // R15
              end
            end else if (tick) begin
              if (t_q.count == TPM_CNT_MAX) begin
                t_d.reload = TPM_CNT_ZERO; // R14
                ev_ovf     = 1'b1; // R5
                t_d.phase  = PH_HALT; // R4
                if (pulse) begin
                  t_d.enable = 1'b0; // R11
                end
              end else begin
                t_d.count = t_q.count + 16'h1; // R1
              end
            end
          end
          PH_HALT: begin
            // Stays stopped until disabled or reset
            t_d.count = t_q.count;
          end
        endcase
      end

      // A new event wins over a clear in the same cycle
      if (ev_meas) begin
        t_d.st[TPM_ST_MEAS] = 1'b1; // R5
      end
      if (ev_ovf) begin
        t_d.st[TPM_ST_OVF] = 1'b1; // R5
      end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        t_q        <= '0;
        t_q.reload <= TPM_RELOAD_RST;
        t_q.mask   <= TPM_MASK_RST;
        t_q.phase  <= PH_IDLE;
      end else begin
        t_q <= t_d;
      end
    end

    // Read view of this instance
    always_comb begin
      rd_vec[n] = 32'h0;
      unique case (roff)
        TPM_OFS_CTL: begin
          rd_vec[n][TPM_CTL_EN]    = t_q.enable;
          rd_vec[n][TPM_CTL_RST]   = t_q.soft_rst;
          rd_vec[n][TPM_CTL_MEAS]  = t_q.meas_mode;
          rd_vec[n][TPM_CTL_BYP]   = t_q.bypass;
          rd_vec[n][TPM_CTL_SLEEP] = sleep; // R18
        end
        TPM_OFS_CLK: begin
          rd_vec[n][TPM_CLK_TPS +: 3] = t_q.tps;
          rd_vec[n][TPM_CLK_FPS +: 3] = t_q.fps;
          rd_vec[n][TPM_CLK_RISE]     = t_q.rise_en;
          rd_vec[n][TPM_CLK_FALL]     = t_q.fall_en;
        end
        TPM_OFS_RELOAD: begin
          rd_vec[n][15:0] = t_q.reload; // R6
        end
        TPM_OFS_COUNT: begin
          rd_vec[n][15:0] = t_q.count;
        end
        TPM_OFS_STAT: begin
          rd_vec[n][1:0]        = t_q.st;
          rd_vec[n][TPM_ST_PIN] = eif.level; // R8
        end
        TPM_OFS_MASK: begin
          rd_vec[n][1:0] = t_q.mask;
        end
        default: begin
          rd_vec[n] = 32'h0;
        end
      endcase
    end

    assign irq_vec[n] = |(t_q.st & t_q.mask);
  end

  // Read data stand for exactly one cycle after the strobe
  always_comb begin
    rdata_d = 32'h0;
    if (rd_i && hit) begin
      rdata_d = rd_vec[inst];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;
  assign irq_o   = |irq_vec;
endmodule : tpm_top

// ---- verif/tpm_top_props.sv ----
// Checker for the measurement timer top, bound to every instance of it.
// Assumes the register map of tpm_pkg and one-cycle read data.
`timescale 1ns/10ps
module tpm_top_props
  import tpm_pkg::*;
#(
  parameter int NUM_INST = TPM_NUM_INST
)(
  // Clock and reset
  input wire logic                clk_i,
  input wire logic                rst_i,
  // Register port
  input wire logic [31:0]         addr_i,
  input wire logic [31:0]         wdata_i,
  input wire logic                wr_i,
  input wire logic                rd_i,
  input wire logic [31:0]         rdata_o,
  // Pins and interrupt
  input wire logic [NUM_INST-1:0] measure_input_pin_i,
  input wire logic [NUM_INST-1:0] sleep_req_i,
  input wire logic                irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic hit;
  assign hit = addr_i[31:9] == 23'h200106 && addr_i[6:0] < 7'h18;
  property p_back(logic [6:0] ofs, logic [31:0] m);
    (wr_i && hit && addr_i[6:0] == ofs) ##2
      (rd_i && addr_i == $past(addr_i, 2))
      |=> (rdata_o & m) == ($past(wdata_i, 3) & m);
  endproperty
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data outside a read");
  a_unmapped_zero: assert property (rd_i && !hit |=> rdata_o == 32'h0)
    else $error("unmapped read returned data");
  a_upper_zero: assert property (rd_i |=> rdata_o[31:16] == 16'h0)
    else $error("upper read bits not zero");
  a_mask_back: assert property (p_back(TPM_OFS_MASK, 32'h3))
    else $error("mask readback wrong");
  a_bypass_back: assert property (p_back(TPM_OFS_CTL, 32'h100))
    else $error("bypass readback wrong");
  a_edge_sel_back: assert property (p_back(TPM_OFS_CLK, 32'h377))
    else $error("edge select readback wrong");
  a_sleep_flag: assert property (rd_i && addr_i == 32'h40020c00
    && sleep_req_i[0] && $past(sleep_req_i[0]) |=> rdata_o[11])
    else $error("sleep flag not shown");
  a_irq_reset: assert property ($fell(rst_i) |-> !irq_o)
    else $error("interrupt high after reset");
  c_irq: cover property ($rose(irq_o));
  c_sleep_rd: cover property (sleep_req_i[0] && rd_i);
  c_pin_sleep: cover property ($rose(measure_input_pin_i[0]) && sleep_req_i[0]);
endmodule : tpm_top_props

bind tpm_top tpm_top_props #(.NUM_INST(NUM_INST)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .measure_input_pin_i(measure_input_pin_i), .sleep_req_i(sleep_req_i),
  .irq_o(irq_o));

// ---- verif/tpm_sig_src.sv ----
// Square-wave source standing in for the signal on one measurement pin.
// Assumes phase lengths in clock cycles, at least 1; idle level is low.
`timescale 1ns/10ps
module tpm_sig_src (
  // Clock
  input  wire logic        clk_i,
  // Waveform control
  input  wire logic        run_i,
  input  wire logic [15:0] hi_len_i,
  input  wire logic [15:0] lo_len_i,
  // Driven pin
  output logic             pin_o = 1'b0
);
  logic [15:0] cnt_q = 16'h0;
  // A new run begins with a rising edge on the next clock
  always_ff @(posedge clk_i) begin
    if (!run_i) begin
      pin_o <= 1'b0;
      cnt_q <= lo_len_i;
    end else if (17'(cnt_q) + 17'h1 >= 17'(pin_o ? hi_len_i : lo_len_i)) begin
      pin_o <= !pin_o;
      cnt_q <= 16'h0;
    end else begin
      cnt_q <= cnt_q + 16'h1;
    end
  end
endmodule : tpm_sig_src

// ---- verif/tb_tpm_top.sv ----
// Self-checking bench for the measurement timer block.
// Assumes one signal source on instance 0; other pins stay low.
`timescale 1ns/10ps
module tb_tpm_top;
  import tpm_pkg::*;
  localparam logic [31:0] B0 = TPM_BUS_BASE + TPM_FIRST_OFS;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [31:0] addr_i = '0;
  logic [31:0] wdata_i = '0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [3:0]  sleep_req_i = '0;
  logic        irq_o;
  logic        pin;
  logic        run = 1'b0;
  logic [15:0] hi_len = 16'd10;
  logic [15:0] lo_len = 16'd10;
  int          errors = 0;
  int          n_checks = 0;
  int          cyc = 0;
  logic [31:0] d, r1, r2;

  always #5 clk_i = ~clk_i;

  tpm_top uut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .measure_input_pin_i({3'b000, pin}), .sleep_req_i(sleep_req_i),
    .irq_o(irq_o));
  tpm_sig_src u_src (.clk_i(clk_i), .run_i(run), .hi_len_i(hi_len),
    .lo_len_i(lo_len), .pin_o(pin));

  function automatic logic [31:0] ra(input int n, input logic [6:0] o);
    return B0 + TPM_INST_STRIDE * 32'(n) + {25'h0, o};
  endfunction : ra
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
    @(posedge clk_i);
  endtask : wr
  task automatic rd(input logic [31:0] a);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
    @(posedge clk_i);
  endtask : rd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_c(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wait_c
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic t_regs;
    rd(ra(3, TPM_OFS_RELOAD));
    chk(d, 32'h0);
    rd(B0 + 32'h200);
    chk(d, 32'h0);
    for (int n = 0; n < 4; n++) begin
      wr(ra(n, TPM_OFS_MASK), 32'(n % 3 + 1));
      rd(ra(n, TPM_OFS_MASK));
      chk(d, 32'(n % 3 + 1));
    end
    $display("test regs done");
  endtask : t_regs
  task automatic t_period;
    wr(ra(0, TPM_OFS_CLK), 32'h100);
    rd(ra(0, TPM_OFS_CLK));
    chk(d, 32'h100);
    wr(ra(0, TPM_OFS_CTL), 32'h105);
    rd(ra(0, TPM_OFS_CTL));
    chk(d, 32'h105);
    run <= 1'b1;
    @(posedge pin);
    wait_c(8);
    rd(ra(0, TPM_OFS_STAT));
    chk(d & 32'h3, 32'h0);
    @(posedge pin);
    wait_c(8);
    rd(ra(0, TPM_OFS_STAT));
    chk(d & 32'h3, 32'h1);
    chk(32'(irq_o), 32'h1);
    rd(ra(0, TPM_OFS_RELOAD));
    r1 = d;
    chk(32'(r1 >= 19 && r1 <= 21), 32'h1);
    wr(ra(0, TPM_OFS_STAT), 32'h3);
    rd(ra(0, TPM_OFS_STAT));
    chk(32'(irq_o), 32'h0);
    hi_len <= 16'd20;
    lo_len <= 16'd20;
    repeat (3) @(posedge pin);
    wait_c(8);
    rd(ra(0, TPM_OFS_RELOAD));
    chk(d - r1, 32'd20);
    run <= 1'b0;
    wait_c(50);
    rd(ra(0, TPM_OFS_RELOAD));
    r2 = d;
    wr(ra(0, TPM_OFS_RELOAD), 32'h1234);
    rd(ra(0, TPM_OFS_RELOAD));
    chk(d, r2);
    wr(ra(0, TPM_OFS_CTL), 32'h100);
    $display("test period done");
  endtask : t_period
  task automatic t_pulse;
    wr(ra(0, TPM_OFS_CLK), 32'h300);
    wr(ra(0, TPM_OFS_STAT), 32'h3);
    wr(ra(0, TPM_OFS_CTL), 32'h105);
    hi_len <= 16'd15;
    lo_len <= 16'd25;
    run <= 1'b1;
    @(posedge pin);
    wait_c(8);
    rd(ra(0, TPM_OFS_STAT));
    chk(d & 32'h3, 32'h0);
    @(negedge pin);
    wait_c(8);
    rd(ra(0, TPM_OFS_RELOAD));
    r1 = d;
    chk(32'(r1 >= 14 && r1 <= 16), 32'h1);
    @(posedge pin);
    wait_c(8);
    rd(ra(0, TPM_OFS_RELOAD));
    chk(d - r1, 32'd10);
    run <= 1'b0;
    wr(ra(0, TPM_OFS_CTL), 32'h100);
    $display("test pulse done");
  endtask : t_pulse
  task automatic t_sleep;
    wr(ra(0, TPM_OFS_CLK), 32'h100);
    wr(ra(0, TPM_OFS_CTL), 32'h105);
    hi_len <= 16'd10;
    lo_len <= 16'd10;
    run <= 1'b1;
    wait_c(60);
    sleep_req_i <= 4'h1;
    wait_c(3);
    wr(ra(0, TPM_OFS_STAT), 32'h3);
    rd(ra(0, TPM_OFS_CTL));
    chk(d, 32'h905);
    wait_c(100);
    rd(ra(0, TPM_OFS_STAT));
    chk(d & 32'h3, 32'h0);
    sleep_req_i <= 4'h0;
    wait_c(100);
    rd(ra(0, TPM_OFS_STAT));
    chk(d & 32'h1, 32'h1);
    wr(ra(0, TPM_OFS_CTL), 32'h107);
    wr(ra(0, TPM_OFS_STAT), 32'h3);
    wait_c(100);
    rd(ra(0, TPM_OFS_STAT));
    chk(d & 32'h3, 32'h0);
    wr(ra(0, TPM_OFS_CTL), 32'h100);
    run <= 1'b0;
    $display("test sleep done");
  endtask : t_sleep
  task automatic t_ovf;
    wr(ra(0, TPM_OFS_CLK), 32'h300);
    wr(ra(0, TPM_OFS_MASK), 32'h3);
    wr(ra(0, TPM_OFS_STAT), 32'h3);
    hi_len <= 16'hffff;
    run <= 1'b1;
    wait_c(20);
    wr(ra(0, TPM_OFS_CTL), 32'h105);
    wait_c(5);
    run <= 1'b0;
    wait_c(65700);
    rd(ra(0, TPM_OFS_RELOAD));
    chk(d, 32'h0);
    rd(ra(0, TPM_OFS_STAT));
    chk(d & 32'h3, 32'h2);
    chk(32'(irq_o), 32'h1);
    rd(ra(0, TPM_OFS_CTL));
    chk(d, 32'h104);
    $display("test overflow done");
  endtask : t_ovf

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      errors++;
      $display("FAIL %0t timeout", $time);
      conclude;
    end
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs;
    t_period;
    t_pulse;
    t_sleep;
    t_ovf;
    conclude;
  end
endmodule : tb_tpm_top
